// [design/s1u_consts.vh]
`ifndef S1U_CONSTS_VH
`define S1U_CONSTS_VH

// Register addresses on the special-function port.
`define S1U_ADDR_LOW 8'hf3
`define S1U_ADDR_HIGH 8'hf2
`define S1U_ADDR_CTRL 8'hf1
`define S1U_ADDR_STAT 8'hf0

// Control register field positions.
`define S1U_LEN_BIT 0
`define S1U_OE_BIT 1
`define S1U_SRC_LO 3
`define S1U_SRC_HI 5
`define S1U_RX_BIT 6
`define S1U_RUN_BIT 7

// Status register field positions.
`define S1U_DONE_BIT 0
`define S1U_BUSY_BIT 1

// Reset values.
`define S1U_LOW_RESET 8'h00
`define S1U_HIGH_RESET 8'h00
`define S1U_SRC_RESET 3'h0
`define S1U_SRC_EXTERNAL 3'h0

// Index of the last bit of a transfer in each length.
`define S1U_LAST_BIT8 5'h07
`define S1U_LAST_BIT16 5'h0f

// Unmapped reads answer with this value.
`define S1U_READ_NONE 8'h00

`endif

// [design/s1u_serial_unit.v]
`default_nettype none
`include "s1u_consts.vh"

// Register port and serial pins of the first serial unit.
// Every output below is a flip-flop, so the pads see no glitches.

module s1u_serial_unit (
   input wire clk,
   input wire rstn,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire serial_one_clock_pin_in,
   output reg serial_one_clock_pin_out,
   output reg serial_one_clock_pin_oe,
   input wire serial_in_pin,
   output reg serial_one_data_out_pin,
   output reg serial_one_data_out_pin_oe,
   output reg serial_one_done_flag
);

   // Half period of the internal serial clock in system clocks.
   // Each step of the source field doubles it; code 000 means external.
   // Code 001 gives one clock per half period, code 111 gives sixty-four.
   // The subtraction wraps for code 000; that result is never used.
   function [7:0] half_count;
      input [2:0] src;
      begin
         half_count = 8'h01 << (src - 3'h1);
      end
   endfunction

   // Shift buffer bytes.
   // The low byte is the software-visible register at its own address.
   // The high byte pairs with it in 16-bit transfers.
   // The next values are worked out in one combinational process.
   reg [7:0] serial_one_shift_low_byte;
   reg [7:0] serial_one_shift_high_byte;
   reg [7:0] next_low;
   reg [7:0] next_high;

   // Control fields.
   reg serial_one_length_select; // Zero means 8 bits, one means 16 bits.
   reg serial_one_output_enable; // Routes the data output pin.
   reg [2:0] clock_source; // Zero selects the partner's clock.
   reg rx_enable; // Set when incoming data are kept in 8-bit mode.
   reg running; // A transfer is in progress.

   // Divider and bit position.
   // The divider counts system clocks inside one half period.
   // The bit counter counts rising edges, up to sixteen.
   reg [7:0] div_count;
   reg [4:0] bit_count;

   // Synchronisers for the pins that come from outside.
   // The clock chain resets high so an idle-high pin gives no false edge.
   // The data input needs no history, so it has only two stages.
   reg sck_meta;
   reg sck_sync;
   reg sck_last;
   reg sin_meta;
   reg sin_sync;

   // Decoded accesses.
   // Unmapped addresses decode to nothing, so such writes are ignored.
   // A start is any control write with the run bit set.
   wire ctrl_wr = wr && (addr == `S1U_ADDR_CTRL);
   wire stat_wr = wr && (addr == `S1U_ADDR_STAT);
   wire low_wr = wr && (addr == `S1U_ADDR_LOW);
   wire high_wr = wr && (addr == `S1U_ADDR_HIGH);
   wire start = ctrl_wr && wdata[`S1U_RUN_BIT];

   // Clock source and edge detection.
   // Internal edges are known one cycle early from the divider, so the
   // shift happens at the same edge at which the pin changes level.
   // External edges arrive three system clocks late; the partner must
   // keep each clock level for several system clocks for this to work.
   wire internal = (clock_source != `S1U_SRC_EXTERNAL);
   wire div_hit = (div_count == (half_count(clock_source) - 8'h01));
   wire int_tick = running && internal && div_hit;
   wire int_fall = int_tick && serial_one_clock_pin_out;
   wire int_rise = int_tick && !serial_one_clock_pin_out;
   // The partner's clock is only looked at after two flip-flops.
   wire ext_fall = running && !internal && sck_last && !sck_sync;
   wire ext_rise = running && !internal && !sck_last && sck_sync;
   wire shift_rise = int_rise || ext_rise;
   wire shift_fall = int_fall || ext_fall;

   // The last rising edge of a transfer ends it.
   // The counter is compared with the last index of the chosen length.
   wire last_bit = (bit_count ==
      (serial_one_length_select ? `S1U_LAST_BIT16 : `S1U_LAST_BIT8));
   wire finish = shift_rise && last_bit;

   // Two flip-flops bring the clock and data pins into our domain.
   // A third copy of the clock gives the edge detector its history.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sck_meta <= 1'b1;
         sck_sync <= 1'b1;
         sck_last <= 1'b1;
         sin_meta <= 1'b0;
         sin_sync <= 1'b0;
      end else begin
         sck_meta <= serial_one_clock_pin_in;
         sck_sync <= sck_meta;
         sck_last <= sck_sync;
         sin_meta <= serial_in_pin;
         sin_sync <= sin_meta;
      end
   end

   // Next values of the shift bytes.
   // A shift edge takes precedence over a software write in the same
   // cycle; the write is lost, which firmware avoids by waiting for done.
   // Bits shifted out of low bit 0 are not kept anywhere.
   // Data shift toward bit 0; the bit leaving low bit 0 goes out first.
   always @* begin
      next_low = serial_one_shift_low_byte;
      next_high = serial_one_shift_high_byte;
      if (shift_rise) begin
         if (serial_one_length_select) begin
            // Both bytes form one chain: input enters high bit 7,
            // high bit 0 walks into low bit 7, so the low byte first
            // sends the lower bits and then fills with incoming ones.
            next_high = {sin_sync, serial_one_shift_high_byte[7:1]};
            next_low = {serial_one_shift_high_byte[0], serial_one_shift_low_byte[7:1]};
            // The same chain serves the combined mode.
            next_low = {serial_one_shift_high_byte[0], serial_one_shift_low_byte[7:1]};
         end else begin
            // In 8-bit mode the high byte only collects input.
            if (rx_enable) begin
               next_high = {sin_sync, serial_one_shift_high_byte[7:1]};
            end
            // The low byte only shifts when it has data to send;
            // in receive-only transfers it is left untouched.
            if (serial_one_output_enable) begin
               next_low = {1'b0, serial_one_shift_low_byte[7:1]};
            end
         end
      end else begin
         // Software may write every bit between shifts.
         // The high byte accepts writes the same way.
         if (low_wr) begin
            next_low = wdata;
         end
         if (high_wr) begin
            next_high = wdata;
         end
      end
   end

   // Shift bytes.
   // Both bytes load their next values on every edge.
   // Bit 0 of the low byte has no defined reset value; zero is used.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         serial_one_shift_low_byte <= `S1U_LOW_RESET;
         serial_one_shift_high_byte <= `S1U_HIGH_RESET;
      end else begin
         serial_one_shift_low_byte <= next_low;
         serial_one_shift_high_byte <= next_high;
      end
   end

   // Control register fields.
   // The reserved bit is not stored and reads back as zero.
   // A write with the run bit clear only changes the configuration.
   // Writing the control register with the run bit set both configures and starts the unit,
   // so firmware must have loaded the data bytes beforehand.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         serial_one_length_select <= 1'b0;
         serial_one_output_enable <= 1'b0;
         clock_source <= `S1U_SRC_RESET;
         rx_enable <= 1'b0;
      end else if (ctrl_wr) begin
         serial_one_length_select <= wdata[`S1U_LEN_BIT];
         serial_one_output_enable <= wdata[`S1U_OE_BIT];
         clock_source <= wdata[`S1U_SRC_HI:`S1U_SRC_LO];
         rx_enable <= wdata[`S1U_RX_BIT];
      end
   end

   // Transfer state and bit counter.
   // The finishing edge clears running in the cycle it sets done.
   // A stray edge while idle does not move the counter.
   // A start while busy restarts the transfer from bit 0.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         running <= 1'b0;
         bit_count <= 5'h00;
      end else if (start) begin
         running <= 1'b1;
         bit_count <= 5'h00;
      end else if (finish) begin
         // Received data stay in the bytes until software writes them or a new transfer shifts them.
         running <= 1'b0;
         bit_count <= 5'h00;
      end else if (shift_rise) begin
         bit_count <= bit_count + 5'h01;
      end
   end

   // Done flag.
   // Software clears it by writing one to the status done bit.
   // A finishing edge wins over a clear in the same cycle.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         serial_one_done_flag <= 1'b0;
      end else if (finish) begin
         serial_one_done_flag <= 1'b1;
      end else if (start || (stat_wr && wdata[`S1U_DONE_BIT])) begin
         serial_one_done_flag <= 1'b0;
      end
   end

   // Internal clock divider.
   // While idle it rests at zero so nothing ticks.
   // It restarts on every start so the first half period is whole.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_count <= 8'h00;
      end else if (start || !running || div_hit) begin
         div_count <= 8'h00;
      end else begin
         div_count <= div_count + 8'h01;
      end
   end

   // Clock pin.
   // Holding the enable on while idle keeps the line high between frames.
   // The pin idles high and each transfer opens with a falling edge;
   // it is driven only while the internal source is chosen.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         serial_one_clock_pin_out <= 1'b1;
         serial_one_clock_pin_oe <= 1'b0;
      end else begin
         serial_one_clock_pin_oe <= internal;
         if (start || !running) begin
            serial_one_clock_pin_out <= 1'b1;
         end else if (int_tick) begin
            serial_one_clock_pin_out <= !serial_one_clock_pin_out;
         end
      end
   end

   // Data output pin.
   // The output enable follows the control bit even while idle.
   // A new bit is presented on each falling edge, after the rising
   // edge that shifted it into low bit 0; the first bit appears at start.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         serial_one_data_out_pin <= 1'b0;
         serial_one_data_out_pin_oe <= 1'b0;
      end else begin
         serial_one_data_out_pin_oe <= serial_one_output_enable;
         if (start || shift_fall) begin
            serial_one_data_out_pin <= serial_one_shift_low_byte[0];
         end
      end
   end

   // Read port: data stand for one cycle after the strobe, else zero.
   // The control read shows the run bit as busy.
   // Reads have no side effects on the shift bytes or the flag.
   // Unmapped addresses read back as zero.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= `S1U_READ_NONE;
      end else if (rd) begin
         case (addr)
            `S1U_ADDR_LOW: rdata <= serial_one_shift_low_byte;
            `S1U_ADDR_HIGH: rdata <= serial_one_shift_high_byte;
            `S1U_ADDR_CTRL: rdata <= {running, rx_enable, clock_source, 1'b0,
               serial_one_output_enable, serial_one_length_select};
            `S1U_ADDR_STAT: rdata <= {6'h00, running, serial_one_done_flag};
            default: rdata <= `S1U_READ_NONE;
         endcase
      end else begin
         rdata <= `S1U_READ_NONE;
      end
   end

endmodule
`default_nettype wire

// [verification/s1u_checker_sva.sv]
`default_nettype none
`include "s1u_consts.vh"
// Watches the register port and the serial output pins of the unit.
module s1u_checker (
   input wire clk,
   input wire rstn,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata,
   input wire serial_one_clock_pin_out,
   input wire serial_one_clock_pin_oe,
   input wire serial_one_data_out_pin,
   input wire serial_one_data_out_pin_oe,
   input wire serial_one_done_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // A control write is the cause behind most of the pin changes.
   wire ctrl_wr = wr && addr == `S1U_ADDR_CTRL;
   property p_rdata_idle; !$past(rd) |-> rdata == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_done_hold; serial_one_done_flag && !wr |=> serial_one_done_flag; endproperty
   a_done_hold: assert property (p_done_hold) else $error("done flag dropped");
   property p_start_clear; ctrl_wr && wdata[7] |=> !serial_one_done_flag; endproperty
   a_start_clear: assert property (p_start_clear) else $error("start kept done");
   property p_out_on; ctrl_wr && wdata[1] |=> ##[0:1] serial_one_data_out_pin_oe; endproperty
   a_out_on: assert property (p_out_on) else $error("data pin not routed");
   property p_clk_drive; ctrl_wr && wdata[5:3] != 3'h0 |=> ##[0:1] serial_one_clock_pin_oe; endproperty
   a_clk_drive: assert property (p_clk_drive) else $error("clock pin not driven");
   property p_clk_idle; !serial_one_clock_pin_oe |-> serial_one_clock_pin_out; endproperty
   a_clk_idle: assert property (p_clk_idle) else $error("idle clock low");
   // Once finished, the clock pin must sit still until software writes again.
   property p_done_quiet; serial_one_done_flag && !wr |=> $stable(serial_one_clock_pin_out); endproperty
   a_done_quiet: assert property (p_done_quiet) else $error("clock moved after done");
   property p_dout_step;
      $changed(serial_one_data_out_pin) && serial_one_clock_pin_oe
         |-> !serial_one_clock_pin_out || $past(wr) || $past(wr, 2);
   endproperty
   a_dout_step: assert property (p_dout_step) else $error("data changed off a falling edge");
   c_long: cover property (ctrl_wr && wdata[7] && wdata[0]);
   c_int_done: cover property ($rose(serial_one_done_flag) && serial_one_clock_pin_oe);
   c_ext_done: cover property ($rose(serial_one_done_flag) && !serial_one_clock_pin_oe);
endmodule
bind s1u_serial_unit s1u_checker s1u_checker_inst (.*);
`default_nettype wire

// [verification/s1u_peer.sv]
`default_nettype none
// Far-side chip: sends a word and captures the unit's bits, LSB first.
module s1u_peer (
   input wire logic sck,
   input wire logic sdo,
   input wire logic arm,
   input wire logic ext,
   input wire logic [4:0] nbits,
   input wire logic [15:0] tx_word,
   output logic sck_drive,
   output logic sdi,
   output logic [15:0] got
);
   timeunit 1ns;
   timeprecision 1ns;
   int k;
   // The line idles high, so the pin is high before an internal start.
   initial begin
      sck_drive = 1'b1;
      sdi = 1'b0;
      got = 16'h0000;
      k = 0;
   end
   // An external clock runs only within the frame; the offset keeps it off the system clock.
   always @(posedge arm) begin
      k = 0;
      got = 16'h0000;
      sdi = ~sdi;
      if (ext) begin
         #17;
         repeat (nbits) begin
            #160 sck_drive = 1'b0;
            #160 sck_drive = 1'b1;
         end
      end
   end
   // Next bit goes out on each falling edge.
   always @(negedge sck) begin
      sdi = tx_word[k];
      k = k + 1;
   end
   // Capture on rising edges; after the last bit the line stops holding its value.
   always @(posedge sck) begin
      got = {sdo, got[15:1]};
      if (k == nbits)
         sdi <= #100 ~sdi;
   end
endmodule
`default_nettype wire

// [verification/sio1_serial_transfer_sequences_test.sv]
`default_nettype none
`include "s1u_consts.vh"
module sio1_serial_transfer_sequences_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rstn = 0, wr = 0, rd = 0, arm = 0, ext = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, v, r;
   logic [4:0] nbits = 5'h08;
   logic [15:0] tx_word = 16'h0000;
   wire [15:0] got;
   wire [7:0] rdata;
   wire ck_out, ck_oe, dout, dout_oe, done, peer_ck, sdi;
   // The pin follows whichever side drives it.
   wire sck = ck_oe ? ck_out : peer_ck;
   int mismatches = 0, check_count = 0, seed = 32'hf9528ec1, i, m;
   s1u_serial_unit s1u_serial_unit_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .serial_one_clock_pin_in(sck), .serial_one_clock_pin_out(ck_out),
      .serial_one_clock_pin_oe(ck_oe), .serial_in_pin(sdi), .serial_one_data_out_pin(dout),
      .serial_one_data_out_pin_oe(dout_oe), .serial_one_done_flag(done));
   s1u_peer s1u_peer_inst (.sck(sck), .sdo(dout), .arm(arm), .ext(ext), .nbits(nbits), .tx_word(tx_word),
      .sck_drive(peer_ck), .sdi(sdi), .got(got));
   always #20 clk = ~clk;
   task automatic check(input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // One whole transfer with the expected buffer contents worked out from the mode.
   task automatic xfer(input logic len, oe, rx, input logic [2:0] src);
      logic [7:0] lo, hi;
      lo = $random(seed);
      hi = $random(seed);
      tx_word = $random(seed);
      nbits = len ? 5'h10 : 5'h08;
      ext = (src == 3'h0);
      wreg(`S1U_ADDR_LOW, lo);
      wreg(`S1U_ADDR_HIGH, hi);
      wreg(`S1U_ADDR_CTRL, {1'b1, rx, src, 1'b0, oe, len});
      arm <= 1'b1;
      @(posedge clk);
      arm <= 1'b0;
      for (i = 0; i < 3000 && done !== 1'b1; i++) @(posedge clk);
      repeat (20) @(posedge clk);
      check(done, 1'b1);
      if (oe) check(len ? got : got >> 8, len ? {hi, lo} : {8'h00, lo});
      rreg(`S1U_ADDR_LOW);
      check(v, len ? tx_word[7:0] : oe ? 8'h00 : lo);
      rreg(`S1U_ADDR_HIGH);
      check(v, len ? tx_word[15:8] : rx ? tx_word[7:0] : hi);
      rreg(`S1U_ADDR_STAT);
      check(v, 8'h01);
      wreg(`S1U_ADDR_STAT, 8'h01);
      rreg(`S1U_ADDR_STAT);
      check(v, 8'h00);
      $display("transfer len=%0d oe=%0d rx=%0d src=%0d finished", len, oe, rx, src);
   endtask
   // Watchdog sized well above ten transfers at the slowest divider.
   initial begin
      #2000000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      rreg(`S1U_ADDR_LOW);
      check(v, 8'h00);
      rreg(`S1U_ADDR_CTRL);
      check(v, 8'h00);
      rreg(8'h55);
      check(v, 8'h00);
      r = $random(seed);
      wreg(`S1U_ADDR_LOW, r);
      rreg(`S1U_ADDR_LOW);
      check(v, r);
      $display("register test finished");
      // First six passes cover every length and mode; source is drawn at random.
      for (m = 0; m < 10; m++) begin
         r = $random(seed);
         xfer(m[0], (m % 3) != 1, (m % 3) != 0, r[1:0] == 2'h0 ? 3'h0 : {1'b0, r[1:0]} + 3'h2);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
